// File: rtl/bfs_selector.sv
// operating button, function menu, fan and ip override
// Functional notes
// - A 3 s hold in normal operation pulses a save-configuration request.
// - A press shorter than 3 s in normal operation opens function selection.
// - Opening selection lights both LEDs for 1 s, then green only.
// - Selection always opens on function 1, fan deactivation.
// - Each further short press while selecting moves to the next function.
// - Function 1 shows green on red off, function 2 green off red on.
// - A 3 s hold while selecting flashes both LEDs twice, then executes.
// - After execution the LEDs return to the normal display and selection ends.
// - With no press for 10 s while selecting, selection ends with no action.
// - Function 1 clears the fan enable setting, function 2 pulses fault acknowledge.
// - A button held from power-up through the 3 s start phase forces automatic IP.
// - An inactive fan is turned on when power temp exceeds 45 C or control temp 60 C.
// - The button may switch the fan off only once until the next restart.
`timescale 1ns/1ps
module bfs_selector
    import bfs_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int NUM_FUNC = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // operator panel
    input wire logic operating_button,
    input bfs_led_s normal_leds,
    output bfs_led_s leds,
    // device actions
    output logic save_cfg,
    output logic fault_ack,
    output logic fan_enable_setting,
    output logic ip_auto,
    // axi4-lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    initial begin
        if (TICK_CYCLES < 1 || NUM_FUNC != 2) begin
            $error("bfs_selector: unsupported parameters");
        end
    end

    // -----------------------------------------------------------------
    // millisecond tick
    // -----------------------------------------------------------------
    logic [31:0] div_r;
    logic tick;

    assign tick = div_r == 32'(TICK_CYCLES - 1);

    always_ff @(posedge mclk) begin
        if (rst || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 32'h0000_0001;
        end
    end

    // -----------------------------------------------------------------
    // button and press timing
    // -----------------------------------------------------------------
    bfs_btn_s btn;
    logic [MSW-1:0] press_ms_r;
    logic long_done_r;
    logic long_hit;
    logic short_press;

    bfs_debounce #(
        .STABLE_MS(DEB_MS)
    ) u_deb (
        .mclk(mclk),
        .rst(rst),
        .tick(tick),
        .raw(operating_button),
        .btn(btn)
    );

    assign long_hit = btn.level && !long_done_r && tick
                      && press_ms_r == MSW'(LONG_MS - 1);
    assign short_press = btn.fall && !long_done_r;

    always_ff @(posedge mclk) begin
        if (rst || !btn.level) begin
            press_ms_r <= '0;
        end else if (tick && !long_done_r) begin
            press_ms_r <= press_ms_r + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || btn.fall) begin
            long_done_r <= 1'b0;
        end else if (long_hit || (state_r == ST_BOOT && btn.level)) begin
            // a press held from start-up is spent: no save, no short press
            long_done_r <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // state machine
    // -----------------------------------------------------------------
    bfs_state_e state_r;
    bfs_state_e state_nxt;
    logic [MSW-1:0] st_ms_r;
    logic [2:0] phase_r;
    logic func_r;
    logic func_nxt;
    logic boot_held_r;
    logic ip_ovr_r;
    logic restart_t;
    logic boot_end;
    logic entry_end;
    logic sel_to;
    logic flash_step;

    assign boot_end = tick && st_ms_r == MSW'(BOOT_MS - 1);
    assign entry_end = tick && st_ms_r == MSW'(ENTRY_MS - 1);
    assign sel_to = tick && st_ms_r == MSW'(SEL_TO_MS - 1);
    assign flash_step = state_r == ST_FLASH && tick && st_ms_r == MSW'(FLASH_MS - 1);
    // entry runs on into select, so the timeout counts from entry
    assign restart_t = (state_nxt != state_r && state_nxt != ST_SEL) || short_press
                       || flash_step;

    always_comb begin
        state_nxt = state_r;
        func_nxt = func_r;
        unique case (state_r)
            ST_BOOT: begin
                if (boot_end) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (short_press) begin
                    state_nxt = ST_ENTRY;
                    func_nxt = 1'b0;
                end
            end
            ST_ENTRY, ST_SEL: begin
                if (long_hit) begin
                    state_nxt = ST_FLASH;
                end else if (short_press) begin
                    state_nxt = ST_SEL;
                    func_nxt = !func_r;
                end else if (state_r == ST_ENTRY && entry_end) begin
                    state_nxt = ST_SEL;
                end else if (sel_to) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_FLASH: begin
                if (flash_step && phase_r == 3'(FLASH_PHASES - 1)) begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_r <= ST_BOOT;
            func_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            func_r <= func_nxt;
        end
    end

    // timer: restarts on state change other than into select, on short press or flash step
    always_ff @(posedge mclk) begin
        if (rst || restart_t) begin
            st_ms_r <= '0;
        end else if (tick) begin
            st_ms_r <= st_ms_r + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || state_r != ST_FLASH) begin
            phase_r <= '0;
        end else if (flash_step) begin
            phase_r <= phase_r + 3'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            boot_held_r <= 1'b1;
            ip_ovr_r <= 1'b0;
        end else if (state_r == ST_BOOT) begin
            // grace while the debouncer settles after reset
            boot_held_r <= boot_held_r && (btn.level || st_ms_r < MSW'(2 * DEB_MS));
            if (boot_end && boot_held_r && btn.level) begin
                ip_ovr_r <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // fan and actions
    // -----------------------------------------------------------------
    logic fan_r;
    logic deact_used_r;
    logic exec_fan;
    logic hot;
    logic sw_fan_wr;
    logic [7:0] pwr_temp_r;
    logic [7:0] ctl_temp_r;
    logic ip_set_r;

    assign exec_fan = state_r == ST_EXEC && !func_r && !deact_used_r;
    assign hot = pwr_temp_r > PWR_LIMIT_C || ctl_temp_r > CTL_LIMIT_C;

    always_ff @(posedge mclk) begin
        if (rst) begin
            fan_r <= FAN_RST;
            deact_used_r <= 1'b0;
        end else begin
            // hardware turn-on wins over any clear
            if (hot && !fan_r) begin
                fan_r <= 1'b1;
            end else if (exec_fan) begin
                fan_r <= 1'b0;
            end else if (sw_fan_wr) begin
                fan_r <= wdata_r[CTRL_FAN_BIT];
            end
            if (exec_fan) begin
                deact_used_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            save_cfg <= 1'b0;
            fault_ack <= 1'b0;
        end else begin
            save_cfg <= long_hit && state_r == ST_IDLE;
            fault_ack <= state_r == ST_EXEC && func_r;
        end
    end

    assign fan_enable_setting = fan_r;
    assign ip_auto = ip_set_r || ip_ovr_r;

    // -----------------------------------------------------------------
    // leds
    // -----------------------------------------------------------------
    bfs_led_s led_nxt;

    always_comb begin
        led_nxt = normal_leds;
        unique case (state_r)
            ST_BOOT: led_nxt = '{green: 1'b1, red: 1'b1};
            ST_ENTRY: led_nxt = '{green: 1'b1, red: 1'b1};
            ST_SEL: led_nxt = '{green: !func_r, red: func_r};
            ST_FLASH: led_nxt = '{green: !phase_r[0], red: !phase_r[0]};
            default: led_nxt = normal_leds;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            leds <= '0;
        end else begin
            leds <= led_nxt;
        end
    end

    // -----------------------------------------------------------------
    // axi4-lite slave
    // -----------------------------------------------------------------
    logic aw_got_r;
    logic w_got_r;
    logic [3:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic do_wr;
    logic wr_map;
    logic rd_map;
    logic [31:0] rd_word;
    logic [31:0] stat_word;
    logic [3:0] waddr;

    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready = !w_got_r && !s_axi_bvalid;
    assign do_wr = aw_got_r && w_got_r && !s_axi_bvalid;
    assign waddr = awaddr_r;
    assign wr_map = waddr == CTRL_OFS || waddr == TEMP_OFS
                    || waddr == IP_OFS || waddr == STAT_OFS;
    assign sw_fan_wr = do_wr && waddr == CTRL_OFS && wstrb_r[0];
    assign stat_word = {22'h00_0000, ip_ovr_r, deact_used_r, btn.level,
                        func_r, phase_r[1:0], state_r, 1'b0};
    assign rd_map = s_axi_araddr == CTRL_OFS || s_axi_araddr == TEMP_OFS
                    || s_axi_araddr == STAT_OFS || s_axi_araddr == IP_OFS;
    assign rd_word = s_axi_araddr == CTRL_OFS ? {31'h0000_0000, fan_r}
                   : s_axi_araddr == TEMP_OFS ? {16'h0000, ctl_temp_r, pwr_temp_r}
                   : s_axi_araddr == STAT_OFS ? stat_word
                   : s_axi_araddr == IP_OFS ? {31'h0000_0000, ip_set_r}
                   : 32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pwr_temp_r <= '0;
            ctl_temp_r <= '0;
            ip_set_r <= IP_RST;
        end else if (do_wr) begin
            if (waddr == TEMP_OFS && wstrb_r[0]) begin
                pwr_temp_r <= wdata_r[7:0];
            end
            if (waddr == TEMP_OFS && wstrb_r[1]) begin
                ctl_temp_r <= wdata_r[TEMP_CTL_POS +: 8];
            end
            if (waddr == IP_OFS && wstrb_r[0]) begin
                ip_set_r <= wdata_r[IP_AUTO_BIT];
            end
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge mclk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : bfs_selector

// File: rtl/bfs_pkg.sv
// shared constants and types of the button function selector
package bfs_pkg;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    localparam int LONG_MS = 3000;
    localparam int ENTRY_MS = 1000;
    localparam int SEL_TO_MS = 10_000;
    localparam int FLASH_MS = 250;
    localparam int FLASH_PHASES = 4;
    localparam int BOOT_MS = 3000;
    localparam int DEB_MS = 10;
    localparam int MSW = 14;

    // -----------------------------------------------------------------
    // temperature limits, degrees C
    // -----------------------------------------------------------------
    localparam logic [7:0] PWR_LIMIT_C = 8'h2d;
    localparam logic [7:0] CTL_LIMIT_C = 8'h3c;

    // -----------------------------------------------------------------
    // register map and resets
    // -----------------------------------------------------------------
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] TEMP_OFS = 4'h4;
    localparam logic [3:0] STAT_OFS = 4'h8;
    localparam logic [3:0] IP_OFS = 4'hc;
    localparam int CTRL_FAN_BIT = 0;
    localparam int IP_AUTO_BIT = 0;
    localparam int TEMP_CTL_POS = 8;
    localparam logic FAN_RST = 1'b1;
    localparam logic IP_RST = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } bfs_btn_s;

    typedef struct packed {
        logic green;
        logic red;
    } bfs_led_s;

    typedef enum logic [2:0] {
        ST_BOOT  = 3'b000,
        ST_IDLE  = 3'b001,
        ST_ENTRY = 3'b010,
        ST_SEL   = 3'b011,
        ST_FLASH = 3'b100,
        ST_EXEC  = 3'b101
    } bfs_state_e;

endpackage : bfs_pkg

// File: rtl/bfs_debounce.sv
// button synchroniser and debouncer
`timescale 1ns/1ps
module bfs_debounce
    import bfs_pkg::*;
#(
    parameter int STABLE_MS = DEB_MS
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // time base
    input wire logic tick,
    // button
    input wire logic raw,
    output bfs_btn_s btn
);

    initial begin
        if (STABLE_MS < 1 || STABLE_MS >= (1 << MSW)) begin
            $error("bfs_debounce: STABLE_MS out of range");
        end
    end

    logic s1_r;
    logic s2_r;
    logic lvl_r;
    logic [MSW-1:0] cnt_r;
    logic [MSW-1:0] cnt_nxt;
    logic differs;
    logic settle;

    assign differs = s2_r != lvl_r;
    assign settle = differs && tick && (cnt_r == MSW'(STABLE_MS - 1));
    assign cnt_nxt = !differs ? '0 : (tick ? cnt_r + 1'b1 : cnt_r);

    // -----------------------------------------------------------------
    // sync then debounce
    // -----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            lvl_r <= 1'b0;
            cnt_r <= '0;
            btn <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
            cnt_r <= settle ? '0 : cnt_nxt;
            if (settle) begin
                lvl_r <= s2_r;
            end
            btn.level <= settle ? s2_r : lvl_r;
            btn.rise <= settle && s2_r;
            btn.fall <= settle && !s2_r;
        end
    end

endmodule : bfs_debounce

// File: tb/bfs_selector_props.sv
// assertion checker for the button function selector
`timescale 1ns/1ps
module bfs_selector_props
    import bfs_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // panel and actions
    input wire bfs_led_s normal_leds,
    input wire bfs_led_s leds,
    input wire logic save_cfg,
    input wire logic fault_ack,
    input wire logic fan_enable_setting,
    // bus handshakes
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    a_save_one_cycle: assert property (save_cfg |=> !save_cfg)
        else $error("save request longer than one cycle");
    a_save_in_idle: assert property (save_cfg |-> leds == normal_leds)
        else $error("save request outside normal display");
    a_ack_one_cycle: assert property (fault_ack |=> !fault_ack)
        else $error("fault acknowledge longer than one cycle");
    a_ack_after_flash: assert property (fault_ack |-> $past(leds, 3) == 2'b00)
        else $error("fault acknowledge without preceding flash");
    a_ack_then_normal: assert property (fault_ack |-> ##[1:3] leds == normal_leds)
        else $error("display not restored after execution");
    a_boot_leds_lit: assert property ($fell(rst) |-> ##[1:3] leds == 2'b11)
        else $error("leds not lit in start phase");
    a_fan_on_restart: assert property ($fell(rst) |-> fan_enable_setting)
        else $error("fan not enabled after restart");
    a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");

    c_save: cover property (save_cfg);
    c_ack: cover property (fault_ack);
    c_fan_off: cover property ($fell(fan_enable_setting));
endmodule : bfs_selector_props

bind bfs_selector bfs_selector_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .mclk(mclk), .rst(rst), .normal_leds(normal_leds), .leds(leds), .save_cfg(save_cfg),
    .fault_ack(fault_ack), .fan_enable_setting(fan_enable_setting),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid)
);

// File: tb/bfs_button_model.sv
// behavioural operator push button with contact bounce
`timescale 1ns/1ps
module bfs_button_model #(
    parameter int TICK_CYCLES = 3
) (
    // control from the bench
    input wire logic mclk,
    input wire logic go,
    input wire logic [15:0] hold_ms,
    // button contact
    output logic operating_button,
    output logic busy
);
    initial begin
        operating_button = 1'b0;
        busy = 1'b0;
    end
    always @(posedge mclk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            // chatter the debouncer must swallow
            for (int i = 0; i < 6; i++) begin
                operating_button <= ~i[0];
                @(posedge mclk);
            end
            operating_button <= 1'b1;
            repeat (int'(hold_ms) * TICK_CYCLES) @(posedge mclk);
            operating_button <= 1'b0;
            repeat (20 * TICK_CYCLES) @(posedge mclk);
            busy <= 1'b0;
        end
    end
endmodule : bfs_button_model

// File: tb/button_function_selector_tb_top.sv
// self-checking bench of the button function selector
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
    $display("Error %s expected %0h seen %0h", nm, exp, got); end end
module button_function_selector_tb_top
    import bfs_pkg::*;
;
    localparam int TC = 2;
    logic mclk = 1'b0;
    logic rst, go, button, busy, save_cfg, fault_ack, fan, ip_auto;
    logic [15:0] hold_ms;
    bfs_led_s normal_leds, leds;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int num_errors = 0;
    int tests_run = 0;
    int save_cnt = 0;
    int ack_cnt = 0;

    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        if (save_cfg === 1'b1) save_cnt++;
        if (fault_ack === 1'b1) ack_cnt++;
    end

    bfs_button_model #(.TICK_CYCLES(TC)) u_btn (.mclk(mclk), .go(go), .hold_ms(hold_ms),
        .operating_button(button), .busy(busy));
    bfs_selector #(.TICK_CYCLES(TC)) dut (
        .mclk(mclk), .rst(rst), .operating_button(button), .normal_leds(normal_leds),
        .leds(leds), .save_cfg(save_cfg), .fault_ack(fault_ack), .fan_enable_setting(fan),
        .ip_auto(ip_auto), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic wait_ms(input int ms);
        repeat (ms * TC) @(posedge mclk);
    endtask : wait_ms

    task automatic press(input int ms);
        int n;
        n = 0;
        hold_ms <= ms[15:0];
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        while (busy === 1'b1 && n < 20000) begin
            @(posedge mclk);
            n++;
        end
        `CHK("button busy", 1'b0, busy)
    endtask : press

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        logic at, wt, bh;
        logic [1:0] rsp;
        bh = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (bh !== 1'b1) begin
            @(negedge mclk);
            at = awvalid & awready;
            wt = wvalid & wready;
            bh = bvalid & bready;
            rsp = bresp;
            @(posedge mclk);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
            if (bh) bready <= 1'b0;
        end
        @(posedge mclk);
        `CHK("bresp", RESP_OKAY, rsp)
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
        logic at, rh;
        logic [1:0] rsp;
        rh = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (rh !== 1'b1) begin
            @(negedge mclk);
            at = arvalid & arready;
            rh = rvalid & rready;
            d = rdata;
            rsp = rresp;
            @(posedge mclk);
            if (at) arvalid <= 1'b0;
            if (rh) rready <= 1'b0;
        end
        @(posedge mclk);
        `CHK("rresp", RESP_OKAY, rsp)
    endtask : axi_read

    task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        axi_read(a, d);
        `CHK("rdata", e, d)
    endtask : chk_reg

    task automatic give_verdict();
        if (num_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_boot_override();
        go <= 1'b0;
        wait_ms(3050);
        `CHK("ip_auto", 1'b1, ip_auto)
        wait_ms(100);
        rst <= 1'b1;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        wait_ms(3010);
        `CHK("ip_auto", 1'b0, ip_auto)
        `CHK("leds", 2'b01, leds)
    endtask : test_boot_override

    task automatic test_regs();
        logic [31:0] d;
        chk_reg(CTRL_OFS, {31'h0000_0000, FAN_RST});
        chk_reg(TEMP_OFS, 32'h0000_0000);
        chk_reg(IP_OFS, {31'h0000_0000, IP_RST});
        axi_write(IP_OFS, 32'h0000_0001);
        `CHK("ip_auto", 1'b1, ip_auto)
        axi_write(IP_OFS, 32'h0000_0000);
        `CHK("ip_auto", 1'b0, ip_auto)
        axi_write(STAT_OFS, 32'h0000_000e);
        axi_read(STAT_OFS, d);
        `CHK("state", 3'h1, d[3:1])
    endtask : test_regs

    task automatic test_save();
        int s0;
        s0 = save_cnt;
        press(3100);
        wait_ms(50);
        `CHK("save count", s0 + 1, save_cnt)
        `CHK("leds", 2'b01, leds)
    endtask : test_save

    task automatic test_select_fan();
        int s0;
        s0 = save_cnt;
        press(100);
        `CHK("leds", 2'b11, leds)
        wait_ms(1050);
        `CHK("leds", 2'b10, leds)
        press(100);
        `CHK("leds", 2'b01, leds)
        press(100);
        `CHK("leds", 2'b10, leds)
        press(3100);
        `CHK("leds", 2'b11, leds)
        wait_ms(250);
        `CHK("leds", 2'b00, leds)
        wait_ms(800);
        `CHK("fan", 1'b0, fan)
        `CHK("leds", 2'b01, leds)
        `CHK("save count", s0, save_cnt)
    endtask : test_select_fan

    task automatic test_heat();
        logic [31:0] t [4];
        logic e [4];
        t = '{32'h0000_002d, 32'h0000_002e, 32'h0000_3c00, 32'h0000_3d00};
        e = '{1'b0, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++) begin
            // temperature first, so the previous hot reading cannot re-arm the fan
            axi_write(TEMP_OFS, t[i]);
            axi_write(CTRL_OFS, 32'h0000_0000);
            chk_reg(CTRL_OFS, {31'h0000_0000, e[i]});
        end
        axi_write(TEMP_OFS, 32'h0000_0000);
    endtask : test_heat

    task automatic test_fan_once();
        int a0;
        a0 = ack_cnt;
        press(100);
        press(3100);
        wait_ms(1050);
        `CHK("fan", 1'b1, fan)
        `CHK("ack count", a0, ack_cnt)
    endtask : test_fan_once

    task automatic test_fault_ack();
        int a0;
        a0 = ack_cnt;
        press(100);
        press(100);
        `CHK("leds", 2'b01, leds)
        press(3100);
        wait_ms(1050);
        `CHK("ack count", a0 + 1, ack_cnt)
        `CHK("fan", 1'b1, fan)
    endtask : test_fault_ack

    task automatic test_timeout();
        int a0;
        a0 = ack_cnt;
        press(100);
        wait_ms(1050);
        `CHK("leds", 2'b10, leds)
        wait_ms(8750);
        `CHK("leds", 2'b10, leds)
        wait_ms(300);
        `CHK("leds", 2'b01, leds)
        `CHK("ack count", a0, ack_cnt)
    endtask : test_timeout

    initial begin
        rst = 1'b1;
        go = 1'b1;
        hold_ms = 16'h0c1c;
        normal_leds = 2'b01;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        test_boot_override();
        test_regs();
        test_save();
        test_select_fan();
        test_heat();
        test_fan_once();
        test_fault_ack();
        test_timeout();
        give_verdict();
    end

    initial begin
        repeat (90_000) @(posedge mclk);
        num_errors++;
        give_verdict();
    end
endmodule : button_function_selector_tb_top
